// [hw/mcuad_classify.sv]
`timescale 1ns/1ps
`default_nettype none

// Pure combinational sorter: one address and direction in, one region out
module mcuad_classify
  import mcuad_pkg::*;
(
  // Request
  input  wire logic [ADDR_W-1:0] i_addr,   // Address under test
  input  wire logic              i_wr,     // Write direction
  // Result
  output var mcuad_region_t      o_region, // Exactly one region
  output var mcuad_hreg_t        o_hreg    // System register, if any
);

  // ----------------------------------------------------------------
  // Region sort, first match wins so every address lands once
  // ----------------------------------------------------------------
  always_comb begin
    o_hreg = HR_NONE;
    if (i_addr <= IO_HI) begin
      o_region = RG_IO;
    end else if (i_addr <= RAM_HI) begin
      o_region = RG_RAM;
    end else if (i_addr <= GAP_HI) begin
      o_region = RG_UNIMP;
    end else if (i_addr <= FLASH_HI) begin
      o_region = RG_FLASH;
    end else if (i_addr <= HIPG_HI) begin
      o_region = RG_SYSREG;
      unique case (i_addr)
        A_BRK_STAT:  o_hreg = HR_BRK_STAT;
        A_RST_SRC:   o_hreg = HR_RST_SRC;
        A_BRK_FLAG:  o_hreg = HR_BRK_FLAG;
        A_FLASH_CTL: o_hreg = HR_FLASH_CTL;
        A_BP_HI:     o_hreg = HR_BP_HI;
        A_BP_LO:     o_hreg = HR_BP_LO;
        A_BP_STAT:   o_hreg = HR_BP_STAT;
        A_SUPPLY:    o_hreg = HR_SUPPLY;
        A_HOLE_A, A_HOLE_B: o_region = RG_UNIMP;
        // Remaining slots are the reserved ones
        default:     o_region = RG_RESV;
      endcase
    end else if (i_addr <= MON_HI) begin
      o_region = RG_MON;
    end else if (i_addr == A_FL_PROT) begin
      o_region = RG_SYSREG;
      o_hreg   = HR_FL_PROT;
    end else if (i_addr < VEC_LO) begin
      o_region = RG_UNIMP;
    end else begin
      o_region = RG_VEC;
      if (i_addr == A_SPLIT && i_wr) begin
        o_region = RG_SYSREG;
        o_hreg   = HR_WDOG;
      end
    end
  end

endmodule

`default_nettype wire

// [hw/mcuad_pkg.sv]
package mcuad_pkg;

  // ----------------------------------------------------------------
  // Address space
  // ----------------------------------------------------------------
  localparam int          ADDR_W      = 16;           // 64 Kbyte space
  localparam int          DATA_W      = 8;            // Byte-wide bus

  // Region bounds, inclusive
  localparam logic [15:0] IO_LO       = 16'h0000;     // I/O block start
  localparam logic [15:0] IO_HI       = 16'h005f;     // I/O block end
  localparam logic [15:0] RAM_LO      = 16'h0060;     // RAM start
  localparam logic [15:0] RAM_HI      = 16'h015f;     // RAM end
  localparam logic [15:0] GAP_LO      = 16'h0160;     // Big hole start
  localparam logic [15:0] GAP_HI      = 16'hdfff;     // Big hole end
  localparam logic [15:0] FLASH_LO    = 16'he000;     // FLASH start
  localparam logic [15:0] FLASH_HI    = 16'hfdff;     // FLASH end
  localparam logic [15:0] HIPG_LO     = 16'hfe00;     // System regs start
  localparam logic [15:0] HIPG_HI     = 16'hfe0f;     // System regs end
  localparam logic [15:0] MON_LO      = 16'hfe10;     // Monitor ROM start
  localparam logic [15:0] MON_HI      = 16'hff48;     // Monitor ROM end
  localparam logic [15:0] HOLE2_LO    = 16'hff49;     // 53-byte hole
  localparam logic [15:0] HOLE2_HI    = 16'hff7d;
  localparam logic [15:0] HOLE3_LO    = 16'hff7f;     // 83-byte hole
  localparam logic [15:0] HOLE3_HI    = 16'hffd1;
  localparam logic [15:0] VEC_LO      = 16'hffd2;     // Vector area start
  localparam logic [15:0] VEC_HI      = 16'hffff;     // Vector area end

  // ----------------------------------------------------------------
  // Fixed system register locations
  // ----------------------------------------------------------------
  localparam logic [15:0] A_BRK_STAT  = 16'hfe00;
  localparam logic [15:0] A_RST_SRC   = 16'hfe01;
  localparam logic [15:0] A_RSV0      = 16'hfe02;
  localparam logic [15:0] A_BRK_FLAG  = 16'hfe03;
  localparam logic [15:0] A_RSV1_LO   = 16'hfe04;
  localparam logic [15:0] A_RSV1_HI   = 16'hfe07;
  localparam logic [15:0] A_FLASH_CTL = 16'hfe08;
  localparam logic [15:0] A_HOLE_A    = 16'hfe09;
  localparam logic [15:0] A_RSV2      = 16'hfe0a;
  localparam logic [15:0] A_HOLE_B    = 16'hfe0b;
  localparam logic [15:0] A_BP_HI     = 16'hfe0c;
  localparam logic [15:0] A_BP_LO     = 16'hfe0d;
  localparam logic [15:0] A_BP_STAT   = 16'hfe0e;
  localparam logic [15:0] A_SUPPLY    = 16'hfe0f;
  localparam logic [15:0] A_FL_PROT   = 16'hff7e;
  localparam logic [15:0] A_SPLIT     = 16'hffff;     // Vector / watchdog

  localparam logic [7:0]  BYTE_ZERO   = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RG_IO, RG_RAM, RG_UNIMP, RG_FLASH, RG_SYSREG, RG_RESV, RG_MON, RG_VEC
  } mcuad_region_t;

  typedef enum logic [3:0] {
    HR_NONE, HR_BRK_STAT, HR_RST_SRC, HR_BRK_FLAG, HR_FLASH_CTL,
    HR_BP_HI, HR_BP_LO, HR_BP_STAT, HR_SUPPLY, HR_FL_PROT, HR_WDOG
  } mcuad_hreg_t;

  // Access request from the processor core
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              rd;
    logic              wr;
    logic [DATA_W-1:0] wdata;
  } mcuad_acc_t;

  // Decoded selection toward the targets
  typedef struct packed {
    mcuad_region_t     region;
    mcuad_hreg_t       hreg;
    logic [ADDR_W-1:0] addr;
  } mcuad_sel_t;

endpackage

// [hw/mcuad_top.sv]
`timescale 1ns/1ps
`default_nettype none

module mcuad_top
  import mcuad_pkg::*;
(
  // Clock and reset
  input  wire logic              i_sys_clk,    // 200 MHz bus clock
  input  wire logic              i_nrst,       // Async reset, low
  // Core request, same clock domain
  input  wire mcuad_acc_t        i_acc,        // Address, strobes, data
  // Target side attributes of the selected byte
  input  wire logic [DATA_W-1:0] i_ro_mask,    // 1 = bit is read-only
  input  wire logic [DATA_W-1:0] i_wo_mask,    // 1 = bit is write-only
  input  wire logic [DATA_W-1:0] i_rdata,      // Target read data
  // Selection toward targets
  output var mcuad_sel_t         o_sel,        // Region, register, addr
  output logic                   o_rd_stb,     // Read strobe to target
  output logic                   o_wr_stb,     // Write strobe to target
  output logic [DATA_W-1:0]      o_wdata,      // Write data
  output logic [DATA_W-1:0]      o_wr_bit_en,  // Per-bit write enable
  // Answer toward core
  output logic [DATA_W-1:0]      o_rdata,      // Cleaned read data
  output logic                   o_rd_valid,   // Read data valid
  // Reset logic
  output logic                   o_illegal_rst_req // One-cycle pulse
);

  // ----------------------------------------------------------------
  // Classification
  // ----------------------------------------------------------------
  mcuad_region_t cls_region;            // Region of current address
  mcuad_hreg_t   cls_hreg;              // System register of address

  mcuad_classify u_classify (
    .i_addr   (i_acc.addr),
    .i_wr     (i_acc.wr),
    .o_region (cls_region),
    .o_hreg   (cls_hreg)
  );

  // ----------------------------------------------------------------
  // Request stage state
  // ----------------------------------------------------------------
  mcuad_sel_t        sel_reg,   sel_next;    // Latched selection
  logic              rd_reg,    rd_next;     // Read strobe
  logic              wr_reg,    wr_next;     // Write strobe
  logic [DATA_W-1:0] wdata_reg, wdata_next;  // Write data
  logic [DATA_W-1:0] wben_reg,  wben_next;   // Bit write enables
  logic              ill_reg,   ill_next;    // Illegal access pulse
  logic              access;                 // Any access this cycle

  assign access = i_acc.rd | i_acc.wr;

  // Next values for the request stage
  always_comb begin
    sel_next   = sel_reg;
    rd_next    = 1'b0;
    wr_next    = 1'b0;
    wdata_next = wdata_reg;
    wben_next  = BYTE_ZERO;
    ill_next   = 1'b0;
    if (access) begin
      sel_next.region = cls_region;
      sel_next.hreg   = cls_hreg;
      sel_next.addr   = i_acc.addr;
      unique case (cls_region)
        RG_UNIMP: begin
          ill_next = 1'b1;
        end
        RG_RESV: begin
          // reserved write dropped
          // Strobes stay low; the slot has no owner, reads get no o_rd_valid answer
        end
        default: begin
          rd_next    = i_acc.rd;
          wr_next    = i_acc.wr;
          wdata_next = i_acc.wdata;
          // reserved bits pass
          // Reserved bits go through unchanged; the master keeps
          // them at harmless values so no extra gating is spent here
          wben_next  = i_acc.wr ? ~i_ro_mask : BYTE_ZERO;
        end
      endcase
    end
  end

  // Register the request stage
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sel_reg   <= '{region: RG_IO, hreg: HR_NONE, addr: IO_LO};
      rd_reg    <= 1'b0;
      wr_reg    <= 1'b0;
      wdata_reg <= BYTE_ZERO;
      wben_reg  <= BYTE_ZERO;
      ill_reg   <= 1'b0;
    end else begin
      sel_reg   <= sel_next;
      rd_reg    <= rd_next;
      wr_reg    <= wr_next;
      wdata_reg <= wdata_next;
      wben_reg  <= wben_next;
      ill_reg   <= ill_next;
    end
  end

  // ----------------------------------------------------------------
  // Read return stage
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rdata_reg, rdata_next;  // Returned byte
  logic              rval_reg,  rval_next;   // Returned byte valid

  // Target answers during the read strobe; clean and return
  always_comb begin
    rdata_next = rdata_reg;
    rval_next  = rd_reg;
    if (rd_reg) begin
      // write-only bits zeroed
      // Zero is a fixed, harmless answer; the target never sees a
      // separate read of those bits, so nothing in it can change
      rdata_next = i_rdata & ~i_wo_mask;
    end
  end

  // Register the return stage
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_reg <= BYTE_ZERO;
      rval_reg  <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rval_reg  <= rval_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, straight from flops
  // ----------------------------------------------------------------
  assign o_sel             = sel_reg;
  assign o_rd_stb          = rd_reg;
  assign o_wr_stb          = wr_reg;
  assign o_wdata           = wdata_reg;
  assign o_wr_bit_en       = wben_reg;
  assign o_rdata           = rdata_reg;
  assign o_rd_valid        = rval_reg;
  assign o_illegal_rst_req = ill_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  // Reference hole test, written apart from the classifier
  logic ref_hole;
  assign ref_hole = (i_acc.addr >= GAP_LO && i_acc.addr <= GAP_HI)
                 || (i_acc.addr >= HOLE2_LO && i_acc.addr <= HOLE2_HI)
                 || (i_acc.addr >= HOLE3_LO && i_acc.addr <= HOLE3_HI)
                 || i_acc.addr == A_HOLE_A || i_acc.addr == A_HOLE_B;

  sequence s_wr_split;
    i_acc.wr && !i_acc.rd && i_acc.addr == A_SPLIT;
  endsequence

  sequence s_rd_split;
    i_acc.rd && !i_acc.wr && i_acc.addr == A_SPLIT;
  endsequence

  sequence s_read_done;
    o_rd_stb ##1 o_rd_valid;
  endsequence

  // Reference reserved-slot test; kept apart from the classifier so
  // a slip in its case table cannot hide behind its own decode
  logic ref_resv;
  assign ref_resv = i_acc.addr == A_RSV0 || i_acc.addr == A_RSV2
                 || (i_acc.addr >= A_RSV1_LO && i_acc.addr <= A_RSV1_HI);

  sequence s_resv_access;
    access && ref_resv;
  endsequence

  chk_hole_reset: assert property (
    access && ref_hole |=> o_illegal_rst_req && !o_rd_stb && !o_wr_stb)
    else $error("hole access did not request reset");

  chk_reset_cause: assert property (
    o_illegal_rst_req |-> $past(access) && $past(ref_hole))
    else $error("reset request without hole access");

  chk_addr_latch: assert property (
    access |=> o_sel.addr == $past(i_acc.addr))
    else $error("selection address not latched");

  chk_io_route: assert property (
    i_acc.rd && i_acc.addr <= IO_HI |=> o_sel.region == RG_IO && o_rd_stb)
    else $error("I/O read misrouted");

  chk_ram_route: assert property (
    access && i_acc.addr >= RAM_LO && i_acc.addr <= RAM_HI
    |=> o_sel.region == RG_RAM)
    else $error("RAM access misrouted");

  chk_flash_route: assert property (
    access && i_acc.addr >= FLASH_LO && i_acc.addr <= FLASH_HI
    |=> o_sel.region == RG_FLASH)
    else $error("FLASH access misrouted");

  chk_mon_route: assert property (
    access && i_acc.addr >= MON_LO && i_acc.addr <= MON_HI
    |=> o_sel.region == RG_MON)
    else $error("monitor ROM access misrouted");

  chk_vec_read: assert property (
    s_rd_split |=> o_sel.region == RG_VEC && o_sel.hreg == HR_NONE
    ##1 o_rd_valid)
    else $error("top byte read not from vectors");

  chk_wdog_write: assert property (
    s_wr_split |=> o_sel.hreg == HR_WDOG && o_wr_stb && !o_rd_stb)
    else $error("top byte write missed watchdog");

  chk_vec_area: assert property (
    i_acc.rd && i_acc.addr >= VEC_LO |=> o_sel.region == RG_VEC)
    else $error("vector read misrouted");

  chk_sysreg_fixed: assert property (
    access && i_acc.addr == A_FLASH_CTL
    |=> o_sel.region == RG_SYSREG && o_sel.hreg == HR_FLASH_CTL)
    else $error("FLASH control not at fixed slot");

  chk_ro_drop: assert property (
    o_wr_stb |-> o_wr_bit_en == ~$past(i_ro_mask))
    else $error("read-only bit enabled for write");

  chk_wo_clean: assert property (
    s_read_done |-> (o_rdata & $past(i_wo_mask)) == BYTE_ZERO)
    else $error("write-only bit leaked on read");

  chk_hole_single: assert property (
    access && i_acc.addr == A_HOLE_B |=> o_illegal_rst_req ##1
    !o_illegal_rst_req || $past(access))
    else $error("single hole not flagged once");

  chk_resv_quiet: assert property (
    s_resv_access |=> o_sel.region == RG_RESV && !o_rd_stb && !o_wr_stb
    && !o_illegal_rst_req)
    else $error("reserved slot access reached a target");

  chk_idle_quiet: assert property (
    !access |=> !o_rd_stb && !o_wr_stb && !o_illegal_rst_req)
    else $error("strobe or reset request without access");

  chk_legal_quiet: assert property (
    access && !ref_hole |=> !o_illegal_rst_req)
    else $error("reset request on a legal address");

  chk_valid_after: assert property (
    o_rd_stb |=> o_rd_valid)
    else $error("read strobe not answered");

  chk_valid_cause: assert property (
    o_rd_valid |-> $past(o_rd_stb))
    else $error("read valid without a strobe");

  chk_wben_idle: assert property (
    !o_wr_stb |-> o_wr_bit_en == BYTE_ZERO)
    else $error("bit enables set without write strobe");

  chk_prot_slot: assert property (
    access && i_acc.addr == A_FL_PROT
    |=> o_sel.region == RG_SYSREG && o_sel.hreg == HR_FL_PROT)
    else $error("FLASH protect not at fixed slot");

  chk_wdog_data: assert property (
    s_wr_split |=> o_wdata == $past(i_acc.wdata))
    else $error("watchdog write data lost");

  chk_upper_hole: assert property (
    access && ((i_acc.addr >= HOLE2_LO && i_acc.addr <= HOLE2_HI)
    || (i_acc.addr >= HOLE3_LO && i_acc.addr <= HOLE3_HI))
    |=> o_sel.region == RG_UNIMP && o_illegal_rst_req)
    else $error("upper hole not treated as unimplemented");

endmodule

`default_nettype wire

// [sim/mcuad_tgt_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Target model: memories and register sets behind the decoder
// ----------------------------------------------------------------
module mcuad_tgt_model
  import mcuad_pkg::*;
(
  // Clock and reset
  input  wire logic              i_sys_clk,  // Bus clock
  input  wire logic              i_nrst,     // Async reset, low
  // From the decoder
  input  wire logic [ADDR_W-1:0] i_req_addr, // Address of the core request
  input  wire logic [ADDR_W-1:0] i_sel_addr, // Registered selection
  input  wire logic              i_rd_stb,   // Read strobe
  // Toward the decoder
  output logic [DATA_W-1:0]      o_ro_mask,  // 1 = read-only bit
  output logic [DATA_W-1:0]      o_wo_mask,  // 1 = write-only bit
  output logic [DATA_W-1:0]      o_rdata     // Read data
);
  logic [DATA_W-1:0] churn_reg;              // Moves every cycle

  // Free pattern shown whenever no read is under way
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      churn_reg <= 8'h3c;
    end else begin
      churn_reg <= churn_reg + 8'h5b;
    end
  end

  // Masks follow the address, so a stuck bit enable shows up
  assign o_ro_mask = ~i_req_addr[7:0];
  // Valid only with the strobe: a late sample picks up garbage
  assign o_rdata   = i_rd_stb ? (i_sel_addr[7:0] ^ 8'ha5) : churn_reg;
  assign o_wo_mask = i_rd_stb ? {i_sel_addr[3:0], i_sel_addr[7:4]}
                              : ~churn_reg;
endmodule

`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Self-checking bench for the address decoder
// ----------------------------------------------------------------
module testbench
  import mcuad_pkg::*;
;

  logic              i_sys_clk = 1'b0;   // 200 MHz
  logic              i_nrst    = 1'b0;   // Held low at start
  mcuad_acc_t        i_acc     = '0;     // Core request
  logic [DATA_W-1:0] ro_mask;            // From target model
  logic [DATA_W-1:0] wo_mask;
  logic [DATA_W-1:0] tgt_rdata;
  mcuad_sel_t        o_sel;
  logic              o_rd_stb;
  logic              o_wr_stb;
  logic              o_rd_valid;
  logic              o_illegal_rst_req;
  logic [DATA_W-1:0] o_wdata;
  logic [DATA_W-1:0] o_wr_bit_en;
  logic [DATA_W-1:0] o_rdata;
  int                err_count   = 0;
  int                check_count = 0;

  // Boundary addresses of every hole and of every region but the system registers; vector area start only
  localparam logic [15:0] RA [19] = '{16'h0000, 16'h005f, 16'h0060,
    16'h015f, 16'h0160, 16'h1234, 16'hdfff, 16'he000, 16'hfdff, 16'hfe09,
    16'hfe0b, 16'hfe10, 16'hff48, 16'hff49, 16'hff57, 16'hff7d, 16'hff7f,
    16'hffd1, 16'hffd2};
  localparam mcuad_region_t RE [19] = '{RG_IO, RG_IO, RG_RAM, RG_RAM,
    RG_UNIMP, RG_UNIMP, RG_UNIMP, RG_FLASH, RG_FLASH, RG_UNIMP, RG_UNIMP,
    RG_MON, RG_MON, RG_UNIMP, RG_UNIMP, RG_UNIMP, RG_UNIMP, RG_UNIMP,
    RG_VEC};
  // Fixed system register slots
  localparam logic [15:0] SA [9] = '{16'hfe00, 16'hfe01, 16'hfe03,
    16'hfe08, 16'hfe0c, 16'hfe0d, 16'hfe0e, 16'hfe0f, 16'hff7e};
  localparam mcuad_hreg_t SE [9] = '{HR_BRK_STAT, HR_RST_SRC, HR_BRK_FLAG,
    HR_FLASH_CTL, HR_BP_HI, HR_BP_LO, HR_BP_STAT, HR_SUPPLY, HR_FL_PROT};
  // Reserved slots, only ever read
  localparam logic [15:0] XA [6] = '{16'hfe02, 16'hfe04, 16'hfe05,
    16'hfe06, 16'hfe07, 16'hfe0a};

  // Clock: invert each half period
  always #2.5 i_sys_clk = ~i_sys_clk;

  mcuad_top DUT (
    .i_sys_clk         (i_sys_clk),
    .i_nrst            (i_nrst),
    .i_acc             (i_acc),
    .i_ro_mask         (ro_mask),
    .i_wo_mask         (wo_mask),
    .i_rdata           (tgt_rdata),
    .o_sel             (o_sel),
    .o_rd_stb          (o_rd_stb),
    .o_wr_stb          (o_wr_stb),
    .o_wdata           (o_wdata),
    .o_wr_bit_en       (o_wr_bit_en),
    .o_rdata           (o_rdata),
    .o_rd_valid        (o_rd_valid),
    .o_illegal_rst_req (o_illegal_rst_req)
  );

  mcuad_tgt_model tgt (
    .i_sys_clk  (i_sys_clk),
    .i_nrst     (i_nrst),
    .i_req_addr (i_acc.addr),
    .i_sel_addr (o_sel.addr),
    .i_rd_stb   (o_rd_stb),
    .o_ro_mask  (ro_mask),
    .o_wo_mask  (wo_mask),
    .o_rdata    (tgt_rdata)
  );

  // Compare one value, count it, report a mismatch
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic finish_test;
    if (err_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One access, judged at the answer cycle and the cycle after
  task automatic acc(input logic [15:0] a, input logic rd, input logic wr,
                     input mcuad_region_t er, input mcuad_hreg_t eh,
                     input logic ok);
    logic [7:0] d;
    // harmless write data
    // The target model keeps no reserved bits, so any byte is safe
    d = a[15:8] ^ a[7:0] ^ 8'h96;
    @(negedge i_sys_clk);
    i_acc = '{addr: a, rd: rd, wr: wr, wdata: d};
    @(negedge i_sys_clk);
    i_acc = '0;
    chk(32'(o_sel.region), 32'(er));
    chk(32'(o_sel.hreg), 32'(eh));
    chk(32'(o_sel.addr), 32'(a));
    chk(32'(o_rd_stb), 32'(rd & ok));
    chk(32'(o_wr_stb), 32'(wr & ok));
    chk(32'(o_illegal_rst_req), 32'(er == RG_UNIMP));
    if (wr && ok) begin
      chk(32'(o_wdata), 32'(d));
      chk(32'(o_wr_bit_en), 32'(a[7:0]));
    end
    @(negedge i_sys_clk);
    chk(32'(o_rd_valid), 32'(rd & ok));
    if (rd && ok) begin
      chk(32'(o_rdata), 32'((a[7:0] ^ 8'ha5) & ~{a[3:0], a[7:4]}));
    end
    // Pulses last one cycle and bit enables drop with the strobe
    chk(32'({o_rd_stb, o_wr_stb, o_illegal_rst_req}), 32'h0);
    chk(32'(o_wr_bit_en), 32'h0);
  endtask

  // Reset for 20 cycles, check the idle state during and after it
  task automatic t_reset;
    @(negedge i_sys_clk);
    i_nrst = 1'b0;
    repeat (20) @(negedge i_sys_clk);
    chk(32'(o_sel), 32'({RG_IO, HR_NONE, 16'h0000}));
    i_nrst = 1'b1;
    @(negedge i_sys_clk);
    chk(32'({o_rd_stb, o_wr_stb, o_rd_valid, o_illegal_rst_req}), 32'h0);
    chk(32'({o_wdata, o_rdata, o_wr_bit_en}), 32'h0);
  endtask

  // Listed region boundaries, read and then written, vector area read only
  task automatic t_regions;
    for (int i = 0; i < 19; i++) begin
      acc(RA[i], 1'b1, 1'b0, RE[i], HR_NONE, RE[i] != RG_UNIMP);
      if (RE[i] != RG_VEC) begin
        acc(RA[i], 1'b0, 1'b1, RE[i], HR_NONE, RE[i] != RG_UNIMP);
      end
    end
    acc(16'hfffe, 1'b1, 1'b0, RG_VEC, HR_NONE, 1'b1);
  endtask

  // Fixed system registers, split location and reserved slots
  task automatic t_sysregs;
    for (int i = 0; i < 9; i++) begin
      acc(SA[i], 1'b1, 1'b0, RG_SYSREG, SE[i], 1'b1);
      acc(SA[i], 1'b0, 1'b1, RG_SYSREG, SE[i], 1'b1);
    end
    acc(16'hffff, 1'b1, 1'b0, RG_VEC, HR_NONE, 1'b1);
    acc(16'hffff, 1'b0, 1'b1, RG_SYSREG, HR_WDOG, 1'b1);
    for (int i = 0; i < 6; i++) begin
      acc(XA[i], 1'b1, 1'b0, RG_RESV, HR_NONE, 1'b0);
    end
  endtask

  // Main sequence, with a second reset in mid-run
  initial begin
    t_reset();
    t_regions();
    acc(16'he123, 1'b0, 1'b1, RG_FLASH, HR_NONE, 1'b1);
    t_reset();
    t_sysregs();
    finish_test();
  end
endmodule

`default_nettype wire
